// ==== hw/cfap_pipeline.sv ====
// cfap_pipeline: capture control and pixel correction pipeline top
`timescale 1ns/1ps
`default_nettype none
module cfap_pipeline (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic trig_pin,
  input wire logic sw_trig,
  input wire cfap_pkg::cfap_mode_t capture_mode,
  input wire logic [cfap_pkg::EXP_W-1:0] exp_cycles,
  input wire cfap_pkg::cfap_coord_t win_org,
  input wire cfap_pkg::cfap_coord_t win_size,
  input wire logic [1:0] cfg_set,
  input wire logic shd_en,
  input wire cfap_pkg::cfap_shd_wr_t shd_wr,
  input wire logic def_off,
  input wire logic def_custom_sel,
  input wire cfap_pkg::cfap_def_wr_t def_wr,
  input wire logic lut_en,
  input wire cfap_pkg::cfap_lut_wr_t lut_wr,
  input wire logic [cfap_pkg::PIX_W-1:0] sen_pix,
  output cfap_pkg::cfap_coord_t sen_addr,
  output logic exposing,
  output cfap_pkg::cfap_beat_t out_beat,
  output logic out_narrow
);
  import cfap_pkg::*;

  // match a stored defect coordinate against a pixel position
  function automatic logic coord_hit(
    input cfap_coord_t a,
    input logic v,
    input cfap_coord_t b
  );
    coord_hit = v && (a == b);
  endfunction

  // block index of a pixel: column and row divided by 16
  function automatic logic [BLK_W-1:0] shd_blk(input cfap_coord_t p);
    shd_blk = {p.y[Y_W-1:BLK_SHIFT], p.x[X_W-1:BLK_SHIFT]};
  endfunction

  // ---------------------------------------------------------------
  // synchronisers and readout timing
  // ---------------------------------------------------------------
  logic trig_s1_reg;               // trigger pin, first stage
  logic trig_s2_reg;               // trigger pin, safe to read
  logic [PIX_W-1:0] sen_s1_reg;    // sensor code, first stage
  logic [PIX_W-1:0] sen_s2_reg;    // sensor code, safe to read
  cfap_beat_t rd_beat;             // slot from the timing block
  cfap_beat_t m1_reg;              // slot delayed one cycle
  cfap_beat_t m2_reg;              // slot aligned with sen_s2_reg

  // trigger pin crosses into ref_clk
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
    end else begin
      trig_s1_reg <= trig_pin;
      trig_s2_reg <= trig_s1_reg;
    end
  end

  // sensor pixel pins pass two flops like any pin
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sen_s1_reg <= 12'h000;
      sen_s2_reg <= 12'h000;
    end else begin
      sen_s1_reg <= sen_pix;
      sen_s2_reg <= sen_s1_reg;
    end
  end

  // exposure and window readout
  cfap_timing u_timing (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .capture_mode(capture_mode),
    .exp_cycles(exp_cycles),
    .trig_lvl(trig_s2_reg),
    .sw_trig(sw_trig),
    .win_org(win_org),
    .win_size(win_size),
    .exposing(exposing),
    .rd_beat(rd_beat)
  );

  // the sensor is addressed with the window position
  assign sen_addr = rd_beat.pos; // see RULE_12

  // strobes follow the sensor code through the pin flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      m1_reg <= '0;
      m2_reg <= '0;
    end else begin
      m1_reg <= rd_beat;
      m2_reg <= m1_reg;
    end
  end

  // ---------------------------------------------------------------
  // stage 1: block shading correction
  // ---------------------------------------------------------------
  logic [GAIN_W-1:0] gain_mem [MAP_N][BLK_N]; // per block gains
  logic [OFF_W-1:0] off_mem [MAP_N][BLK_N];   // per block offsets
  logic [1:0] map_reg;             // map in use for this frame
  logic [BLK_W-1:0] blk;           // block of current pixel
  logic [GAIN_W-1:0] gain;         // looked up gain
  logic [OFF_W-1:0] off;           // looked up offset
  logic [19:0] prod;               // code times gain
  logic [14:0] sum;                // scaled product plus offset
  logic [PIX_W-1:0] shd_pix;       // corrected, clamped code
  cfap_beat_t p1_reg;              // shading stage output

  // map storage; unity gain and zero offset out of reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int m = 0; m < MAP_N; m++) begin
        for (int b = 0; b < BLK_N; b++) begin
          gain_mem[m][b] <= GAIN_ONE;
          off_mem[m][b] <= 8'h00;
        end
      end
    end else if (shd_wr.en && shd_wr.map < 2'h3) begin
      // writes to a fourth map are ignored
      gain_mem[shd_wr.map][shd_wr.blk] <= shd_wr.gain;
      off_mem[shd_wr.map][shd_wr.blk] <= shd_wr.off;
    end
  end

  // the configuration set takes effect between frames
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      map_reg <= 2'h0;
    end else if (!m2_reg.fv && cfg_set < 2'h3) begin
      map_reg <= cfg_set; // see RULE_02
    end
  end

  // gain and offset of the block holding the pixel
  always_comb begin
    blk = shd_blk(m2_reg.pos); // see RULE_01
    gain = gain_mem[map_reg][blk];
    off = off_mem[map_reg][blk];
    prod = 20'(sen_s2_reg) * 20'(gain);
    sum = {1'b0, prod[19:GAIN_FRAC]} + {7'h00, off};
    // saturate at the top code
    if (sum > 15'h0FFF) begin
      shd_pix = 12'hFFF;
    end else begin
      shd_pix = sum[PIX_W-1:0];
    end
  end

  // shading register; bypass when disabled
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      p1_reg <= '0;
    end else begin
      p1_reg <= m2_reg;
      p1_reg.data <= shd_en ? shd_pix : sen_s2_reg; // see RULE_03, RULE_23
    end
  end

  // ---------------------------------------------------------------
  // stage 2: defect replacement
  // ---------------------------------------------------------------
  cfap_coord_t cust_pos [DEF_N];   // uploaded coordinates
  logic [DEF_N-1:0] cust_vld;      // uploaded entry in use
  logic [FACT_N-1:0] fact_hit;     // factory map matches
  logic [DEF_N-1:0] cust_hit;      // custom map matches
  logic is_def;                    // pixel under test is defective
  logic first_col;                 // pixel opens its line
  logic [PIX_W-1:0] repl;          // neighbour value to use
  cfap_beat_t p2_reg;              // pixel under test
  cfap_beat_t p3_reg;              // defect stage output

  // custom map upload, empty after reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cust_vld <= 8'h00;
      for (int i = 0; i < DEF_N; i++) begin
        cust_pos[i] <= '0;
      end
    end else if (def_wr.en) begin
      cust_vld[def_wr.idx] <= def_wr.valid; // see RULE_06
      cust_pos[def_wr.idx] <= def_wr.pos;
    end
  end

  // compare the pixel against every stored coordinate
  for (genvar i = 0; i < FACT_N; i++) begin : g_fact
    assign fact_hit[i] = coord_hit(FACT_MAP[i], 1'b1, p2_reg.pos);
  end
  for (genvar i = 0; i < DEF_N; i++) begin : g_cust
    assign cust_hit[i] = coord_hit(cust_pos[i], cust_vld[i], p2_reg.pos);
  end

  // map choice; both controls low selects the factory map
  assign is_def = def_custom_sel ? (|cust_hit) : (|fact_hit); // see RULE_06, RULE_08

  // left neighbour is the corrected previous output, so a run of
  // bad pixels copies the last good one along the line
  assign first_col = (p2_reg.pos.x == win_org.x);
  assign repl = first_col ? p1_reg.data : p3_reg.data; // see RULE_04, RULE_05

  // one-pixel look-ahead gives the right neighbour
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      p2_reg <= '0;
    end else begin
      p2_reg <= p1_reg;
    end
  end

  // replacement, unless correction is switched off
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      p3_reg <= '0;
    end else begin
      p3_reg <= p2_reg;
      if (is_def && !def_off && p2_reg.lv) begin // see RULE_07, RULE_23
        p3_reg.data <= repl;
      end
    end
  end

  // ---------------------------------------------------------------
  // stage 3: remap table and output
  // ---------------------------------------------------------------
  logic [OUT_W-1:0] lut_mem [LUT_N]; // one entry per converter code

  // table load; any curve, gamma included, is computed off-chip
  always_ff @(posedge ref_clk) begin
    if (lut_wr.en) begin
      lut_mem[lut_wr.addr] <= lut_wr.data; // see RULE_11
    end
  end

  // table lookup narrows the code; otherwise full width passes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_beat <= '0;
      out_narrow <= 1'b0;
    end else begin
      out_beat <= p3_reg;
      out_narrow <= lut_en;
      if (lut_en) begin
        out_beat.data <= {4'h0, lut_mem[p3_reg.data]}; // see RULE_09, RULE_10, RULE_23
      end
    end
  end
endmodule
`default_nettype wire

// ==== include/cfap_pkg.sv ====
// cfap_pkg: constants, types and overview of the frame acquisition pipeline
// Overview of operation
// RULE_01 - one gain and offset per 16x16 block
// RULE_02 - three shading maps, chosen by configuration set
// RULE_03 - shading enable; off passes pixels unchanged
// RULE_04 - corrects single defects and clusters up to five
// RULE_05 - defect replaced by left or right neighbour
// RULE_06 - factory map plus uploaded custom coordinate map
// RULE_07 - defect correction can be switched off
// RULE_08 - factory map corrected by default after power-up
// RULE_09 - table maps every converter code to user value
// RULE_10 - table output narrows 12 bit to 8 bit
// RULE_11 - no gamma hardware, only loaded tables
// RULE_12 - window readout transfers only selected region
// RULE_13 - window at least 128x2, aligned starts
// RULE_14 - exactly two modes: free-running and triggered
// RULE_15 - free-run frames continuous with line/frame strobes
// RULE_16 - free-run exposure from programmed value
// RULE_17 - trigger rise starts, fall ends exposure
// RULE_18 - rise during frame waits for line strobe fall
// RULE_19 - rise outside frame starts after fixed delay
// RULE_20 - trigger fall only after frame strobe low
// RULE_21 - exposure follows each pulse independently
// RULE_22 - software command can also trigger
// RULE_23 - order: shading, defect, table, then output
package cfap_pkg;
  localparam int X_W = 8;                 // column coordinate width
  localparam int Y_W = 6;                 // row coordinate width
  localparam int PIX_W = 12;              // converter code width
  localparam int OUT_W = 8;               // table output width
  localparam int BLK_SHIFT = 4;           // 16 pixel block edge
  localparam int BLK_W = 6;               // block index width
  localparam int BLK_N = 64;              // blocks per map
  localparam int MAP_N = 3;               // stored shading maps
  localparam int GAIN_W = 8;              // block gain width
  localparam int GAIN_FRAC = 6;           // gain fraction bits
  localparam logic [7:0] GAIN_ONE = 8'h40; // unity gain
  localparam int OFF_W = 8;               // block offset width
  localparam int LUT_N = 4096;            // table entries
  localparam int DEF_N = 8;               // custom map entries
  localparam int DEF_IW = 3;              // custom map index width
  localparam int FACT_N = 4;              // factory map entries
  localparam int EXP_W = 16;              // exposure count width
  localparam int CLK_NS = 40;             // ref_clk period
  localparam int TRIG_DELAY_NS = 200;     // fixed untimed start delay
  localparam logic [15:0] TRIG_DELAY_CYC =
    16'((TRIG_DELAY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] LINE_GAP_CYC = 3'h4; // blank cycles after a line

  // pixel position
  typedef struct packed {
    logic [Y_W-1:0] y;
    logic [X_W-1:0] x;
  } cfap_coord_t;

  // one pixel slot with its strobes
  typedef struct packed {
    logic fv;
    logic lv;
    cfap_coord_t pos;
    logic [PIX_W-1:0] data;
  } cfap_beat_t;

  // shading map write
  typedef struct packed {
    logic en;
    logic [1:0] map;
    logic [BLK_W-1:0] blk;
    logic [GAIN_W-1:0] gain;
    logic [OFF_W-1:0] off;
  } cfap_shd_wr_t;

  // custom defect map write
  typedef struct packed {
    logic en;
    logic [DEF_IW-1:0] idx;
    logic valid;
    cfap_coord_t pos;
  } cfap_def_wr_t;

  // remap table write
  typedef struct packed {
    logic en;
    logic [PIX_W-1:0] addr;
    logic [OUT_W-1:0] data;
  } cfap_lut_wr_t;

  typedef enum logic {MODE_FREE = 1'b0, MODE_TRIG = 1'b1} cfap_mode_t;

  typedef enum logic [1:0] {
    EXP_IDLE = 2'b00,
    EXP_ALIGN = 2'b01,
    EXP_DELAY = 2'b10,
    EXP_ON = 2'b11
  } cfap_exp_t;

  // factory defect coordinates, fixed at build
  localparam cfap_coord_t FACT_MAP [FACT_N] = '{
    '{y: 6'h02, x: 8'h10}, '{y: 6'h05, x: 8'h21},
    '{y: 6'h05, x: 8'h22}, '{y: 6'h1A, x: 8'h80}};
endpackage

// ==== hw/cfap_timing.sv ====
// cfap_timing: exposure control and window readout strobe generation
`timescale 1ns/1ps
`default_nettype none
module cfap_timing (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire cfap_pkg::cfap_mode_t capture_mode,
  input wire logic [cfap_pkg::EXP_W-1:0] exp_cycles,
  input wire logic trig_lvl,
  input wire logic sw_trig,
  input wire cfap_pkg::cfap_coord_t win_org,
  input wire cfap_pkg::cfap_coord_t win_size,
  output logic exposing,
  output cfap_pkg::cfap_beat_t rd_beat
);
  import cfap_pkg::*;

  cfap_exp_t exp_reg;              // exposure state
  logic [EXP_W-1:0] cnt_reg;       // delay / exposure counter
  logic sw_src_reg;                // exposure started by software
  logic trig_d_reg;                // trigger level one cycle ago
  logic lv_d_reg;                  // line strobe one cycle ago
  logic fv_reg;                    // frame readout active
  logic [X_W-1:0] col_reg;         // column within window
  logic [Y_W-1:0] row_reg;         // row within window
  logic [2:0] gap_reg;             // line blanking countdown
  logic trig_rise, trig_fall, lv, lv_fall, cnt_last, hw_end, timed_end, start_rd;

  assign trig_rise = trig_lvl & ~trig_d_reg;
  assign trig_fall = ~trig_lvl & trig_d_reg;
  assign lv = fv_reg & (gap_reg == 3'h0);
  assign lv_fall = lv_d_reg & ~lv;
  assign cnt_last = (cnt_reg <= 16'h0001);
  // pulse end stops integration and starts readout
  assign hw_end = (capture_mode == MODE_TRIG) & ~sw_src_reg & trig_fall
    & (exp_reg != EXP_IDLE); // see RULE_17
  // programmed length for free run and software shots
  assign timed_end = (exp_reg == EXP_ON) & cnt_last
    & ((capture_mode == MODE_FREE) | sw_src_reg); // see RULE_16
  assign start_rd = hw_end | timed_end;
  assign exposing = (exp_reg == EXP_ON);

  // edge history
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      trig_d_reg <= 1'b0;
      lv_d_reg <= 1'b0;
    end else begin
      trig_d_reg <= trig_lvl;
      lv_d_reg <= lv;
    end
  end

  // exposure state machine, one of two modes
  always_ff @(posedge ref_clk or negedge nrst) begin // see RULE_14
    if (!nrst) begin
      exp_reg <= EXP_IDLE;
      cnt_reg <= 16'h0000;
      sw_src_reg <= 1'b0;
    end else begin
      unique case (exp_reg)
        EXP_IDLE: begin
          if (capture_mode == MODE_FREE) begin
            if (!fv_reg) begin // see RULE_15
              exp_reg <= EXP_ON;
              cnt_reg <= exp_cycles;
              sw_src_reg <= 1'b0;
            end
          end else if (trig_rise | sw_trig) begin // see RULE_22
            sw_src_reg <= ~trig_rise;
            cnt_reg <= TRIG_DELAY_CYC;
            exp_reg <= fv_reg ? EXP_ALIGN : EXP_DELAY; // see RULE_18, RULE_19
          end
        end
        EXP_ALIGN: begin
          if (start_rd) begin
            exp_reg <= EXP_IDLE;
          end else if (lv_fall) begin // see RULE_18
            exp_reg <= EXP_ON;
            cnt_reg <= exp_cycles;
          end
        end
        EXP_DELAY: begin
          if (start_rd) begin
            exp_reg <= EXP_IDLE;
          end else if (cnt_last) begin // see RULE_19
            exp_reg <= EXP_ON;
            cnt_reg <= exp_cycles;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        EXP_ON: begin
          if (start_rd) begin
            exp_reg <= EXP_IDLE; // see RULE_21
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
      endcase
    end
  end

  // window readout counters; a start during readout is dropped
  always_ff @(posedge ref_clk or negedge nrst) begin // see RULE_12, RULE_20
    if (!nrst) begin
      fv_reg <= 1'b0;
      col_reg <= 8'h00;
      row_reg <= 6'h00;
      gap_reg <= 3'h0;
    end else if (!fv_reg) begin
      fv_reg <= start_rd;
      col_reg <= 8'h00;
      row_reg <= 6'h00;
      gap_reg <= 3'h0;
    end else if (gap_reg != 3'h0) begin
      gap_reg <= gap_reg - 3'h1;
    end else if (col_reg == win_size.x - 8'h01) begin
      col_reg <= 8'h00;
      gap_reg <= LINE_GAP_CYC;
      if (row_reg == win_size.y - 6'h01) begin
        fv_reg <= 1'b0;
      end else begin
        row_reg <= row_reg + 6'h01;
      end
    end else begin
      col_reg <= col_reg + 8'h01;
    end
  end

  // readout slot towards the sensor and the pipeline
  always_comb begin
    rd_beat.fv = fv_reg;
    rd_beat.lv = lv;
    rd_beat.pos.x = win_org.x + col_reg;
    rd_beat.pos.y = win_org.y + row_reg;
    rd_beat.data = 12'h000;
  end
endmodule
`default_nettype wire

// ==== tb/cfap_pipeline_assertions.sv ====
// cfap_pipeline_assertions: port-level checks of the acquisition pipeline
`timescale 1ns/1ps
`default_nettype none
module cfap_pipeline_assertions (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic trig_pin,
  input wire cfap_pkg::cfap_mode_t capture_mode,
  input wire logic lut_en,
  input wire cfap_pkg::cfap_coord_t win_org,
  input wire cfap_pkg::cfap_coord_t win_size,
  input wire logic exposing,
  input wire cfap_pkg::cfap_beat_t out_beat,
  input wire logic out_narrow
);
  import cfap_pkg::*;
  logic [8:0] x_end; // first column past the window
  logic [6:0] y_end; // first row past the window
  assign x_end = {1'h0, win_org.x} + {1'h0, win_size.x};
  assign y_end = {1'h0, win_org.y} + {1'h0, win_size.y};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_LV_IN_FV: assert property (out_beat.lv |-> out_beat.fv)
    else $error("line strobe outside frame");
  AST_LINE_GAP: assert property ($fell(out_beat.lv) |-> !out_beat.lv [*4])
    else $error("line gap too short");
  AST_POS_X: assert property (out_beat.lv |-> {1'h0, out_beat.pos.x} >= {1'h0, win_org.x}
    && {1'h0, out_beat.pos.x} < x_end) else $error("column outside window");
  AST_POS_Y: assert property (out_beat.lv |-> {1'h0, out_beat.pos.y} >= {1'h0, win_org.y}
    && {1'h0, out_beat.pos.y} < y_end) else $error("row outside window");
  AST_NARROW_ZERO: assert property (out_narrow && out_beat.lv |-> out_beat.data[11:8] == 4'h0)
    else $error("narrow pixel has upper bits");
  AST_NARROW_OFF: assert property (!lut_en |=> !out_narrow)
    else $error("narrow without table");
  AST_NARROW_ON: assert property (lut_en |=> out_narrow)
    else $error("table output not flagged");
  AST_READOUT: assert property ($fell(exposing) && !out_beat.fv |-> ##[5:8] out_beat.fv)
    else $error("no frame after exposure");
  AST_TRIG_DELAY: assert property ($rose(trig_pin) && capture_mode == MODE_TRIG
    && !exposing && !out_beat.fv |-> ##[6:10] exposing) else $error("late exposure start");
endmodule
bind cfap_pipeline cfap_pipeline_assertions chk (.ref_clk(ref_clk), .nrst(nrst),
  .trig_pin(trig_pin), .capture_mode(capture_mode), .lut_en(lut_en), .win_org(win_org),
  .win_size(win_size), .exposing(exposing), .out_beat(out_beat), .out_narrow(out_narrow));
`default_nettype wire

// ==== tb/cfap_sensor_model.sv ====
// cfap_sensor_model: pixel array and trigger source beside the pipeline
`timescale 1ns/1ps
`default_nettype none
module cfap_sensor_model (
  input wire logic ref_clk,
  input wire cfap_pkg::cfap_coord_t sen_addr,
  input wire logic frame_on,
  output var logic [cfap_pkg::PIX_W-1:0] sen_pix,
  output var logic trig_pin
);
  import cfap_pkg::*;
  initial trig_pin = 1'h0;
  // array answers in the slot of its address; the pin flops in the design
  // delay code and strobes alike, so they stay aligned
  // pixel value is its column and low four row bits, so every slot of a window up to 16 rows is distinct
  always_comb sen_pix = {sen_addr.y[3:0], sen_addr.x};
  // trigger pulse; the fall waits for the frame strobe to drop
  task automatic pulse(input int width);
    @(posedge ref_clk);
    trig_pin <= 1'h1;
    repeat (width) @(posedge ref_clk);
    while (frame_on !== 1'h0) @(posedge ref_clk);
    trig_pin <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ==== tb/cfap_pipeline_test.sv ====
// cfap_pipeline_test: self-checking bench for the acquisition pipeline
`timescale 1ns/1ps
`default_nettype none
module cfap_pipeline_test;
  import cfap_pkg::*;
  // controls of one frame and the narrow flag they give
  typedef struct packed {logic shd; logic [1:0] cfg; logic doff; logic cust; logic pixel_remap_table;
    logic nar;} cfap_row_t;
  // rows: plain, map1, map2+custom+table, defects off, shading off, map1+custom+table
  localparam cfap_row_t ROWS [6] = '{7'h00, 7'h50, 7'h67, 7'h4B, 7'h14, 7'h57};
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic sw_trig = 1'h0;
  logic shd_en = 1'h0;
  logic def_off = 1'h0;
  logic def_custom_sel = 1'h0;
  logic lut_en = 1'h0;
  logic [1:0] cfg_set = 2'h0;
  cfap_mode_t capture_mode = MODE_FREE;
  logic [EXP_W-1:0] exp_cycles = 16'h0003;
  cfap_coord_t win_org = 14'h0208; // row 2, column 8: aligned start
  cfap_coord_t win_size = 14'h0480; // 128 wide, 4 rows
  cfap_shd_wr_t shd_wr = '0;
  cfap_def_wr_t def_wr = '0;
  cfap_lut_wr_t lut_wr = '0;
  logic trig_pin;
  logic [PIX_W-1:0] sen_pix;
  cfap_coord_t sen_addr;
  logic exposing;
  cfap_beat_t out_beat;
  logic out_narrow;
  int miscompares = 0;
  int compares = 0;
  logic [7:0] gain_m [3][64]; // shading gain model
  logic [7:0] off_m [3][64]; // shading offset model
  logic [7:0] lut_m [4096]; // table model
  // custom map: one single defect and a cluster of five
  cfap_coord_t cust [6] = '{14'h0340, 14'h0441, 14'h0442, 14'h0443, 14'h0444, 14'h0445};
  cfap_pipeline dut (.ref_clk(ref_clk), .nrst(nrst), .trig_pin(trig_pin), .sw_trig(sw_trig),
    .capture_mode(capture_mode), .exp_cycles(exp_cycles), .win_org(win_org),
    .win_size(win_size), .cfg_set(cfg_set), .shd_en(shd_en), .shd_wr(shd_wr),
    .def_off(def_off), .def_custom_sel(def_custom_sel), .def_wr(def_wr), .lut_en(lut_en),
    .lut_wr(lut_wr), .sen_pix(sen_pix), .sen_addr(sen_addr), .exposing(exposing),
    .out_beat(out_beat), .out_narrow(out_narrow));
  cfap_sensor_model partner (.ref_clk(ref_clk), .sen_addr(sen_addr), .frame_on(out_beat.fv),
    .sen_pix(sen_pix), .trig_pin(trig_pin));
  always #20 ref_clk = ~ref_clk;
  task automatic complete_run;
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    compares++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %0h want %0h", $time, what, seen, want);
    end
  endtask
  // expected shaded value: (pix*gain)>>6 + offset, clipped
  function automatic logic [11:0] shade(cfap_coord_t p, cfap_row_t r);
    logic [5:0] b;
    logic [19:0] v;
    b = {p.y[5:4], p.x[7:4]};
    v = {8'h00, p.y[3:0], p.x};
    if (r.shd) v = ((v * 20'(gain_m[r.cfg][b])) >> 6) + 20'(off_m[r.cfg][b]);
    return (v > 20'h00FFF) ? 12'hFFF : v[11:0];
  endfunction
  function automatic bit is_def(cfap_coord_t p, cfap_row_t r);
    if (r.doff) return 1'b0;
    for (int i = 0; i < 6; i++) if (r.cust && cust[i] === p) return 1'b1;
    for (int i = 0; i < FACT_N; i++) if (!r.cust && FACT_MAP[i] === p) return 1'b1;
    return 1'b0;
  endfunction
  task automatic wait_fv(input logic lvl);
    for (int t = 0; t < 3000 && out_beat.fv !== lvl; t++) @(negedge ref_clk);
  endtask
  task automatic expo_len(output int len);
    for (int t = 0; t < 3000 && exposing !== 1'h1; t++) @(negedge ref_clk);
    for (len = 0; len < 3000 && exposing === 1'h1; len++) @(negedge ref_clk);
  endtask
  task automatic shd_put(input logic [1:0] m, input logic [5:0] b, input logic [7:0] g,
      input logic [7:0] o);
    @(posedge ref_clk);
    shd_wr <= '{1'h1, m, b, g, o};
    gain_m[m][b] = g;
    off_m[m][b] = o;
    @(posedge ref_clk);
    shd_wr <= '0;
  endtask
  // applies a row, skips frames already under way, checks every pixel
  task automatic run_frame(input cfap_row_t r, input logic skip);
    logic [11:0] prev;
    logic [11:0] v;
    int n;
    @(posedge ref_clk);
    {shd_en, cfg_set, def_off, def_custom_sel, lut_en} <= {r.shd, r.cfg, r.doff, r.cust, r.pixel_remap_table};
    if (skip) begin
      wait_fv(1'h1);
      wait_fv(1'h0);
    end
    wait_fv(1'h1);
    n = 0;
    while (out_beat.fv === 1'h1 && n < 600) begin
      if (out_beat.lv === 1'h1) begin
        v = shade(out_beat.pos, r);
        if (is_def(out_beat.pos, r)) v = prev;
        prev = v;
        check(out_beat.data, r.pixel_remap_table ? {4'h0, lut_m[v]} : v, "pixel");
        check(out_narrow, r.nar, "narrow");
        n++;
      end
      @(negedge ref_clk);
    end
    check(n, 512, "pixel count");
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end
  initial begin
    int l1;
    int l2;
    for (int i = 0; i < 192; i++) {gain_m[i / 64][i % 64], off_m[i / 64][i % 64]} = 16'h4000;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'h1;
    for (int i = 0; i < 4096; i++) begin
      lut_m[i] = 8'(i >> 4) ^ 8'(i);
      @(posedge ref_clk);
      lut_wr <= '{1'h1, 12'(i), lut_m[i]};
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      def_wr <= '{1'h1, 3'(i), 1'h1, cust[i]};
    end
    @(posedge ref_clk);
    {def_wr, lut_wr} <= '0;
    shd_put(2'h0, 6'h00, 8'h40, 8'h05);
    shd_put(2'h1, 6'h01, 8'h80, 8'h03);
    shd_put(2'h1, 6'h08, 8'hFF, 8'hFF);
    shd_put(2'h2, 6'h02, 8'h20, 8'h00);
    foreach (ROWS[i]) run_frame(ROWS[i], 1'h1);
    // free-run exposure follows the programmed count
    @(posedge ref_clk);
    exp_cycles <= 16'h0007;
    expo_len(l1);
    expo_len(l1);
    check(l1, 7, "free exposure");
    @(posedge ref_clk);
    capture_mode <= MODE_TRIG;
    repeat (1200) @(negedge ref_clk);
    // two pulses of different width, readout after each
    fork
      partner.pulse(30);
      expo_len(l1);
    join
    run_frame(ROWS[2], 1'h0);
    check(l1, 30 - TRIG_DELAY_CYC, "pulse exposure");
    fork
      partner.pulse(50);
      expo_len(l2);
    join
    run_frame(ROWS[2], 1'h0);
    check(l2 - l1, 20, "exposure step");
    // second rise during readout waits for a line end
    fork
      begin
        partner.pulse(30);
        repeat (50) @(posedge ref_clk);
        partner.pulse(20);
      end
      begin
        expo_len(l1);
        for (l2 = 0; l2 < 3000 && exposing !== 1'h1; l2++) @(negedge ref_clk);
        for (l2 = 0; l2 < 200 && out_beat.lv !== 1'h0; l2++) @(negedge ref_clk);
        check(l2, 5, "overlap alignment");
      end
    join
    run_frame(ROWS[5], 1'h0);
    // software shot lasts the programmed count
    @(posedge ref_clk);
    sw_trig <= 1'h1;
    @(posedge ref_clk);
    sw_trig <= 1'h0;
    expo_len(l1);
    check(l1, 7, "software exposure");
    run_frame(ROWS[0], 1'h0);
    // reset mid-run, then factory defects fixed with no set-up
    @(posedge ref_clk);
    nrst <= 1'h0;
    capture_mode <= MODE_FREE;
    @(negedge ref_clk);
    check({out_beat, exposing, out_narrow}, 0, "reset outputs");
    check(sen_addr, win_org, "reset address");
    @(posedge ref_clk);
    nrst <= 1'h1;
    run_frame(ROWS[0], 1'h1);
    complete_run();
  end
endmodule
`default_nettype wire
